//--- hdl/fss_pkg.sv
package fss_pkg;

  // node space and bus widths
  localparam int NODE_COUNT = 127;
  localparam int NODE_AW    = 7;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;
  localparam int ENABLE_W   = 128;
  localparam logic [NODE_AW-1:0] NODE_LAST = 7'h7e;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_NODE_SEL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG_IDENT  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CFG_MAP    = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MODE       = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_ENABLE0    = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_ENABLE1    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_ENABLE2    = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ENABLE3    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h20;

  // status word bit positions
  localparam int FLG_PRESENT    = 0;
  localparam int FLG_RUNNING    = 1;
  localparam int FLG_IDENT_DIFF = 2;
  localparam int FLG_NOT_EN     = 3;
  localparam int FLG_FAULT      = 4;
  localparam int FLG_ALARM      = 5;
  localparam int FLG_DIAG       = 6;
  localparam int FLG_ADDR_DIFF  = 7;
  localparam int FLG_MAP_DIFF   = 8;
  localparam int FLG_CLEAR_N    = 9;
  localparam int FLG_ACK_N      = 10;
  localparam int FLAG_W         = 11;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 11'h600;

  // per-node configuration word layout
  localparam int CFG_W        = 48;
  localparam int CFG_IDENT_LO = 32;
  localparam int CFG_SIZE_LO  = 24;
  localparam int CFG_STN_LO   = 16;
  localparam int CFG_CHK_LO   = 0;

  // mode register bit and bus responses
  localparam int MODE_EMU_BIT = 0;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // events reported by the fieldbus engine
  typedef enum logic [3:0] {
    EV_ONLINE      = 4'h0,
    EV_EXCHANGE    = 4'h1,
    EV_PARAM_IDENT = 4'h2,
    EV_LINK_FAULT  = 4'h3,
    EV_DATA_SIZE   = 4'h4,
    EV_VALID_RESP  = 4'h5,
    EV_ALARM       = 4'h6,
    EV_DIAG        = 4'h7,
    EV_STATION     = 4'h8,
    EV_CHECKSUM    = 4'h9,
    EV_EMU_CLEAR   = 4'ha,
    EV_EMU_ALARM   = 4'hb,
    EV_EMU_ACK     = 4'hc
  } fss_evt_e;

endpackage : fss_pkg

//--- hdl/fss_ram.sv
`timescale 1ns/1ps
// simple dual-port memory, registered read
module fss_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 127,
  parameter int AW    = 7
) (
  input  wire logic             aclk,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // write port and registered read port
  always_ff @(posedge aclk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : fss_ram

//--- hdl/fss_node_status.sv
// Notes on behaviour
// - present flag follows station presence
// - running only when present, enabled, exchanging
// - identity differs flag from id compare
// - not-enabled flag is inverse of enable
// - fault on identity mismatch during parameterization
// - fault on any link-layer fault
// - fault on cyclic data size mismatch
// - fault clears on next valid response
// - alarm waiting flag follows alarm state
// - diag waiting flag follows diag state
// - station address compared with controller value
// - map checksum compared with controller value
// - emulated clear state reads 0 in clear
// - emulated alarm ack reported per node
// - ack reads 0 once acknowledged, else 1
// - controller checksum compared with own checksum
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fss_node_status (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [fss_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                        s_axi_awvalid,
  output logic                             s_axi_awready,
  input  wire logic [fss_pkg::DATA_W-1:0]  s_axi_wdata,
  input  wire logic [3:0]                  s_axi_wstrb,
  input  wire logic                        s_axi_wvalid,
  output logic                             s_axi_wready,
  output logic [1:0]                       s_axi_bresp,
  output logic                             s_axi_bvalid,
  input  wire logic                        s_axi_bready,
  input  wire logic [fss_pkg::ADDR_W-1:0]  s_axi_araddr,
  input  wire logic                        s_axi_arvalid,
  output logic                             s_axi_arready,
  output logic [fss_pkg::DATA_W-1:0]       s_axi_rdata,
  output logic [1:0]                       s_axi_rresp,
  output logic                             s_axi_rvalid,
  input  wire logic                        s_axi_rready,
  input  wire logic                        evt_valid,
  output logic                             evt_ready,
  input  wire logic [fss_pkg::NODE_AW-1:0] evt_node,
  input  wire fss_pkg::fss_evt_e           evt_code,
  input  wire logic [15:0]                 evt_value
);

  typedef enum logic [1:0] {S_INIT, S_IDLE, S_EV_UPD, S_AX_RD} fss_state_e;

  typedef struct packed {
    fss_state_e                       st;
    logic [fss_pkg::NODE_AW-1:0]      init_idx;
    logic [fss_pkg::NODE_AW-1:0]      ev_node;
    fss_pkg::fss_evt_e                ev_code;
    logic [15:0]                      ev_value;
    logic [fss_pkg::NODE_AW-1:0]      node_sel;
    logic [23:0]                      stg_ident;
    logic [23:0]                      stg_map;
    logic                             emu_mode;
    logic [fss_pkg::ENABLE_W-1:0]     enable;
    logic                             aw_v;
    logic [fss_pkg::ADDR_W-1:0]       aw_addr;
    logic                             w_v;
    logic [fss_pkg::DATA_W-1:0]       w_data;
    logic [3:0]                       w_strb;
    logic                             b_v;
    logic [1:0]                       b_resp;
    logic                             ar_v;
    logic [fss_pkg::ADDR_W-1:0]       ar_addr;
    logic                             r_v;
    logic [fss_pkg::DATA_W-1:0]       r_data;
    logic [1:0]                       r_resp;
  } fss_state_s;

  fss_state_s q;
  fss_state_s d;

  logic                              st_we;
  logic [fss_pkg::NODE_AW-1:0]       st_waddr;
  logic [fss_pkg::FLAG_W-1:0]        st_wdata;
  logic [fss_pkg::FLAG_W-1:0]        st_rdata;
  logic                              cfg_we;
  logic [fss_pkg::NODE_AW-1:0]       cfg_waddr;
  logic [fss_pkg::CFG_W-1:0]         cfg_wdata;
  logic [fss_pkg::CFG_W-1:0]         cfg_rdata;
  logic [fss_pkg::NODE_AW-1:0]       mem_raddr;
  logic                              ar_status;

  // byte-lane merge of a written word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] data,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

  // word aligned address, unaligned ones fall out of the map
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return (a[1:0] == 2'h0) ? a : 8'hff;
  endfunction : word_addr

  // per-node status memory and configuration memory
  fss_ram #(
    .WIDTH (fss_pkg::FLAG_W),
    .DEPTH (fss_pkg::NODE_COUNT),
    .AW    (fss_pkg::NODE_AW)
  ) u_status_ram (
    .aclk  (aclk),
    .we    (st_we),
    .waddr (st_waddr),
    .wdata (st_wdata),
    .raddr (mem_raddr),
    .rdata (st_rdata)
  );

  fss_ram #(
    .WIDTH (fss_pkg::CFG_W),
    .DEPTH (fss_pkg::NODE_COUNT),
    .AW    (fss_pkg::NODE_AW)
  ) u_cfg_ram (
    .aclk  (aclk),
    .we    (cfg_we),
    .waddr (cfg_waddr),
    .wdata (cfg_wdata),
    .raddr (mem_raddr),
    .rdata (cfg_rdata)
  );

  // handshake outputs
  assign ar_status     = q.ar_v && !q.r_v && (word_addr(q.ar_addr) == fss_pkg::OFS_STATUS);
  assign s_axi_awready = !q.aw_v && !q.b_v;
  assign s_axi_wready  = !q.w_v && !q.b_v;
  assign s_axi_arready = !q.ar_v && !q.r_v;
  assign evt_ready     = (q.st == S_IDLE) && !ar_status;
  assign s_axi_bvalid  = q.b_v;
  assign s_axi_bresp   = q.b_resp;
  assign s_axi_rvalid  = q.r_v;
  assign s_axi_rdata   = q.r_data;
  assign s_axi_rresp   = q.r_resp;

  // next state of the whole block
  always_comb
  begin
    logic [fss_pkg::FLAG_W-1:0] f;
    logic [31:0]                wv;
    logic                       en;
    f         = st_rdata;
    wv        = merge_bytes(32'h0, q.w_data, q.w_strb);
    en        = q.enable[q.node_sel];
    d         = q;
    st_we     = 1'b0;
    st_waddr  = q.ev_node;
    st_wdata  = fss_pkg::FLAGS_RESET;
    cfg_we    = 1'b0;
    cfg_waddr = q.node_sel;
    cfg_wdata = '0;
    mem_raddr = ar_status ? q.node_sel : evt_node;

    // write address and data capture, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_v    = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_v    = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.b_v && s_axi_bready)
    begin
      d.b_v = 1'b0;
    end

    // register write once both halves are held
    if (q.aw_v && q.w_v && (q.st != S_INIT))
    begin
      d.aw_v   = 1'b0;
      d.w_v    = 1'b0;
      d.b_v    = 1'b1;
      d.b_resp = fss_pkg::RESP_OKAY;
      case (word_addr(q.aw_addr))
        fss_pkg::OFS_NODE_SEL:
        begin
          wv         = merge_bytes({25'h0, q.node_sel}, q.w_data, q.w_strb);
          d.node_sel = (wv[6:0] > fss_pkg::NODE_LAST) ? fss_pkg::NODE_LAST : wv[6:0];
        end
        fss_pkg::OFS_CFG_IDENT:
        begin
          wv          = merge_bytes({8'h0, q.stg_ident}, q.w_data, q.w_strb);
          d.stg_ident = wv[23:0];
        end
        fss_pkg::OFS_CFG_MAP:
        begin
          // controller station and checksum, commits the node's config
          wv        = merge_bytes({8'h0, q.stg_map}, q.w_data, q.w_strb);
          d.stg_map = wv[23:0];
          cfg_we    = 1'b1;
          cfg_wdata = {q.stg_ident[15:0], q.stg_ident[23:16], wv[23:0]};
        end
        fss_pkg::OFS_MODE:
        begin
          wv         = merge_bytes({31'h0, q.emu_mode}, q.w_data, q.w_strb);
          d.emu_mode = wv[fss_pkg::MODE_EMU_BIT];
        end
        fss_pkg::OFS_ENABLE0, fss_pkg::OFS_ENABLE1, fss_pkg::OFS_ENABLE2, fss_pkg::OFS_ENABLE3:
        begin
          // one enable bit per node address
          wv = merge_bytes(q.enable[32*q.aw_addr[3:2] +: 32], q.w_data, q.w_strb);
          d.enable[32*q.aw_addr[3:2] +: 32] = wv;
          d.enable[fss_pkg::ENABLE_W-1]     = 1'b0;
        end
        fss_pkg::OFS_STATUS:
        begin
          d.b_resp = fss_pkg::RESP_OKAY; // read only, write ignored
        end
        default:
        begin
          d.b_resp = fss_pkg::RESP_SLVERR;
        end
      endcase
    end

    // read address capture and direct register reads
    if (s_axi_arvalid && s_axi_arready)
    begin
      d.ar_v    = 1'b1;
      d.ar_addr = s_axi_araddr;
    end
    if (q.r_v && s_axi_rready)
    begin
      d.r_v = 1'b0;
    end
    if (q.ar_v && !q.r_v && !ar_status)
    begin
      d.ar_v   = 1'b0;
      d.r_v    = 1'b1;
      d.r_resp = fss_pkg::RESP_OKAY;
      case (word_addr(q.ar_addr))
        fss_pkg::OFS_NODE_SEL:  d.r_data = {25'h0, q.node_sel};
        fss_pkg::OFS_CFG_IDENT: d.r_data = {8'h0, q.stg_ident};
        fss_pkg::OFS_CFG_MAP:   d.r_data = {8'h0, q.stg_map};
        fss_pkg::OFS_MODE:      d.r_data = {31'h0, q.emu_mode};
        fss_pkg::OFS_ENABLE0, fss_pkg::OFS_ENABLE1, fss_pkg::OFS_ENABLE2, fss_pkg::OFS_ENABLE3:
        begin
          d.r_data = q.enable[32*q.ar_addr[3:2] +: 32];
        end
        default:
        begin
          d.r_data = 32'h0;
          d.r_resp = fss_pkg::RESP_SLVERR;
        end
      endcase
    end

    // status engine
    case (q.st)
      S_INIT:
      begin
        // clear every node's flags and configuration after reset
        st_we      = 1'b1;
        st_waddr   = q.init_idx;
        st_wdata   = fss_pkg::FLAGS_RESET;
        cfg_we     = 1'b1;
        cfg_waddr  = q.init_idx;
        cfg_wdata  = '0;
        d.init_idx = q.init_idx + 7'h01;
        if (q.init_idx == fss_pkg::NODE_LAST)
        begin
          d.st = S_IDLE;
        end
      end
      S_IDLE:
      begin
        if (ar_status)
        begin
          d.st = S_AX_RD;
        end
        else if (evt_valid)
        begin
          d.ev_node  = evt_node;
          d.ev_code  = evt_code;
          d.ev_value = evt_value;
          d.st       = S_EV_UPD;
        end
      end
      S_EV_UPD:
      begin
        // read-modify-write of the addressed node only
        case (q.ev_code)
          fss_pkg::EV_ONLINE:
          begin
            f[fss_pkg::FLG_PRESENT] = q.ev_value[0];
            if (!q.ev_value[0])
            begin
              f[fss_pkg::FLG_RUNNING] = 1'b0;
            end
          end
          fss_pkg::EV_EXCHANGE:
          begin
            f[fss_pkg::FLG_RUNNING] = q.ev_value[0] && f[fss_pkg::FLG_PRESENT];
          end
          fss_pkg::EV_PARAM_IDENT:
          begin
            f[fss_pkg::FLG_IDENT_DIFF] = q.ev_value != cfg_rdata[fss_pkg::CFG_IDENT_LO +: 16];
            if (f[fss_pkg::FLG_IDENT_DIFF])
            begin
              f[fss_pkg::FLG_FAULT] = 1'b1;
            end
          end
          fss_pkg::EV_LINK_FAULT:
          begin
            f[fss_pkg::FLG_FAULT] = 1'b1;
          end
          fss_pkg::EV_DATA_SIZE:
          begin
            // a correctly sized answer is a valid response
            f[fss_pkg::FLG_FAULT] = q.ev_value != {8'h0, cfg_rdata[fss_pkg::CFG_SIZE_LO +: 8]};
          end
          fss_pkg::EV_VALID_RESP:
          begin
            f[fss_pkg::FLG_FAULT] = 1'b0;
          end
          fss_pkg::EV_ALARM:
          begin
            f[fss_pkg::FLG_ALARM] = q.ev_value[0];
          end
          fss_pkg::EV_DIAG:
          begin
            f[fss_pkg::FLG_DIAG] = q.ev_value[0];
          end
          fss_pkg::EV_STATION:
          begin
            f[fss_pkg::FLG_ADDR_DIFF] = q.ev_value[7:0] != cfg_rdata[fss_pkg::CFG_STN_LO +: 8];
          end
          fss_pkg::EV_CHECKSUM:
          begin
            f[fss_pkg::FLG_MAP_DIFF] = q.ev_value != cfg_rdata[fss_pkg::CFG_CHK_LO +: 16];
          end
          fss_pkg::EV_EMU_CLEAR:
          begin
            f[fss_pkg::FLG_CLEAR_N] = !q.ev_value[0];
          end
          fss_pkg::EV_EMU_ALARM:
          begin
            f[fss_pkg::FLG_ACK_N] = 1'b1;
          end
          fss_pkg::EV_EMU_ACK:
          begin
            f[fss_pkg::FLG_ACK_N] = 1'b0;
          end
          default:
          begin
            f = st_rdata;
          end
        endcase
        st_we    = 1'b1;
        st_waddr = q.ev_node;
        st_wdata = f;
        d.st     = S_IDLE;
      end
      S_AX_RD:
      begin
        // compose live status of the selected node
        f = st_rdata;
        f[fss_pkg::FLG_RUNNING] = st_rdata[fss_pkg::FLG_RUNNING] && en;
        f[fss_pkg::FLG_NOT_EN]  = !en;
        if (!q.emu_mode)
        begin
          f[fss_pkg::FLG_CLEAR_N] = 1'b1;
          f[fss_pkg::FLG_ACK_N]   = 1'b1;
        end
        d.r_data = {21'h0, f};
        d.r_resp = fss_pkg::RESP_OKAY;
        d.r_v    = 1'b1;
        d.ar_v   = 1'b0;
        d.st     = S_IDLE;
      end
      default:
      begin
        d.st = S_IDLE;
      end
    endcase
  end

  // single state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

endmodule : fss_node_status

//--- testbench/fss_properties.sv
`timescale 1ns/1ps
// handshake and status relations seen at the block ports
module fss_properties (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [fss_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [fss_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic                       evt_valid,
  input wire logic                       evt_ready
);
  logic [fss_pkg::ADDR_W-1:0] rd_addr_q;

  // address of the read in flight
  always_ff @(posedge aclk)
    if (s_axi_arvalid && s_axi_arready)
      rd_addr_q <= s_axi_araddr;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until taken
  property p_b_stands; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_stands: assert property (p_b_stands) else $error("write answer dropped");
  property p_r_stands; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_stands: assert property (p_r_stands) else $error("read answer dropped");
  property p_no_new_wr; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_no_new_wr: assert property (p_no_new_wr) else $error("write taken while answering");
  property p_no_new_rd; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_no_new_rd: assert property (p_no_new_rd) else $error("read taken while answering");
  property p_err_zero; s_axi_rvalid && s_axi_rresp == fss_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read carries data");
  property p_evt_gap; evt_valid && evt_ready |=> !evt_ready; endproperty
  a_evt_gap: assert property (p_evt_gap) else $error("event taken in update cycle");
  property p_init; $rose(aresetn) |-> !evt_ready && !s_axi_bvalid && !s_axi_rvalid; endproperty
  a_init: assert property (p_init) else $error("busy at reset release");
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:132] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write not answered");
  property p_rd_ans; s_axi_arvalid && s_axi_arready |-> ##[1:132] s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_flags; s_axi_rvalid && rd_addr_q == fss_pkg::OFS_STATUS |->
    !(s_axi_rdata[1] && s_axi_rdata[3]) && !(s_axi_rdata[1] && !s_axi_rdata[0]) && s_axi_rdata[31:11] == 21'h0;
  endproperty
  a_flags: assert property (p_flags) else $error("inconsistent status word");

  // main scenarios reached
  c_evt: cover property (evt_valid && evt_ready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == fss_pkg::RESP_SLVERR);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule : fss_properties

bind fss_node_status fss_properties fss_properties_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .evt_valid, .evt_ready);

//--- testbench/fss_slave_model.sv
`timescale 1ns/1ps
// remote stations as seen through the fieldbus engine: one event per request
module fss_slave_model (
  input wire logic               aclk,
  input wire logic               go,
  input wire logic [6:0]         node_in,
  input wire fss_pkg::fss_evt_e  code_in,
  input wire logic [15:0]        val_in,
  input wire logic [3:0]         stall,
  input wire logic               evt_ready,
  output logic                   evt_valid,
  output logic [6:0]             evt_node,
  output fss_pkg::fss_evt_e      evt_code,
  output logic [15:0]            evt_value,
  output logic                   done
);
  // wait, offer, hold until taken, then scramble the released node and value lines
  initial
  begin
    evt_valid = 1'b0;
    evt_node = 7'h0;
    evt_code = fss_pkg::EV_ONLINE;
    evt_value = 16'h0;
    done = 1'b0;
    forever
    begin
      @(posedge aclk);
      done <= 1'b0;
      if (go)
      begin
        repeat (stall) @(posedge aclk);
        evt_valid <= 1'b1;
        evt_node <= node_in;
        evt_code <= code_in;
        evt_value <= val_in;
        do @(posedge aclk); while (!evt_ready);
        evt_valid <= 1'b0;
        evt_node <= ~node_in;
        evt_value <= ~val_in;
        done <= 1'b1;
      end
    end
  end
endmodule : fss_slave_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
// self-checking bench for the node status block
module testbench;
  logic              aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              evt_valid, evt_ready, go, done;
  logic [7:0]        s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb, stall;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [6:0]        evt_node, go_node;
  logic [15:0]       evt_value, go_val;
  fss_pkg::fss_evt_e evt_code, go_code;
  int                failures, cmp_count;

  fss_node_status fss_node_status_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .evt_valid, .evt_ready, .evt_node, .evt_code, .evt_value);
  fss_slave_model fss_slave_model_i (.aclk, .go, .node_in(go_node), .code_in(go_code), .val_in(go_val),
    .stall, .evt_ready, .evt_valid, .evt_node, .evt_code, .evt_value, .done);

  // 125 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  // count one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bus write; ready lines of the answers stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid);
    chk({29'h0, s_axi_bvalid, s_axi_bresp}, {29'h0, 1'b1, er});
  endtask : wr

  // bus read with data and response compare
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    while (!s_axi_rvalid);
    chk(s_axi_rdata, ed);
    chk({29'h0, s_axi_rvalid, s_axi_rresp}, {29'h0, 1'b1, er});
  endtask : rd

  // status word of one node
  task automatic st(input logic [6:0] n, input logic [10:0] e);
    wr(fss_pkg::OFS_NODE_SEL, {25'h0, n}, fss_pkg::RESP_OKAY);
    rd(fss_pkg::OFS_STATUS, {21'h0, e}, fss_pkg::RESP_OKAY);
  endtask : st

  // one station event, then its status
  task automatic evst(input logic [6:0] n, input fss_pkg::fss_evt_e c, input logic [15:0] v, input logic [10:0] e);
    go_node <= n;
    go_code <= c;
    go_val <= v;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    repeat (400)
    begin
      @(posedge aclk);
      if (done) break;
    end
    st(n, e);
  endtask : evst

  // reset values, read-only and unmapped places
  task automatic t_regs;
    st(7'h00, 11'h608);
    rd(fss_pkg::OFS_CFG_IDENT, 32'h0, fss_pkg::RESP_OKAY);
    rd(8'h40, 32'h0, fss_pkg::RESP_SLVERR);
    rd(8'h22, 32'h0, fss_pkg::RESP_SLVERR);
    wr(8'h40, 32'h1, fss_pkg::RESP_SLVERR);
    wr(fss_pkg::OFS_STATUS, 32'hffffffff, fss_pkg::RESP_OKAY);
    st(7'h00, 11'h608);
    wr(fss_pkg::OFS_NODE_SEL, 32'hff, fss_pkg::RESP_OKAY);
    rd(fss_pkg::OFS_NODE_SEL, 32'h7e, fss_pkg::RESP_OKAY);
  endtask : t_regs

  // presence, exchange and enable on the last node
  task automatic t_exchange;
    wr(fss_pkg::OFS_ENABLE3, 32'hc0000000, fss_pkg::RESP_OKAY);
    rd(fss_pkg::OFS_ENABLE3, 32'h40000000, fss_pkg::RESP_OKAY);
    evst(7'h7e, fss_pkg::EV_EXCHANGE, 16'h1, 11'h600);
    evst(7'h7e, fss_pkg::EV_ONLINE, 16'h1, 11'h601);
    evst(7'h7e, fss_pkg::EV_EXCHANGE, 16'h1, 11'h603);
    st(7'h7d, 11'h608);
    wr(fss_pkg::OFS_ENABLE0, 32'h1, fss_pkg::RESP_OKAY);
    st(7'h00, 11'h600);
    wr(fss_pkg::OFS_ENABLE3, 32'h0, fss_pkg::RESP_OKAY);
    st(7'h7e, 11'h609);
    wr(fss_pkg::OFS_ENABLE3, 32'h40000000, fss_pkg::RESP_OKAY);
    st(7'h7e, 11'h603);
    evst(7'h7e, fss_pkg::EV_ONLINE, 16'h0, 11'h600);
  endtask : t_exchange

  // fault, pending and mismatch flags of a configured node
  task automatic t_events;
    wr(fss_pkg::OFS_NODE_SEL, 32'h7, fss_pkg::RESP_OKAY);
    wr(fss_pkg::OFS_CFG_IDENT, 32'h00041234, fss_pkg::RESP_OKAY);
    wr(fss_pkg::OFS_CFG_MAP, 32'h0007beef, fss_pkg::RESP_OKAY);
    evst(7'h07, fss_pkg::EV_PARAM_IDENT, 16'h1235, 11'h61c);
    evst(7'h07, fss_pkg::EV_VALID_RESP, 16'h0, 11'h60c);
    evst(7'h07, fss_pkg::EV_LINK_FAULT, 16'h0, 11'h61c);
    evst(7'h07, fss_pkg::EV_DATA_SIZE, 16'h0004, 11'h60c);
    evst(7'h07, fss_pkg::EV_DATA_SIZE, 16'h0005, 11'h61c);
    evst(7'h07, fss_pkg::EV_VALID_RESP, 16'h0, 11'h60c);
    evst(7'h07, fss_pkg::EV_PARAM_IDENT, 16'h1234, 11'h608);
    evst(7'h07, fss_pkg::EV_ALARM, 16'h1, 11'h628);
    evst(7'h07, fss_pkg::EV_DIAG, 16'h1, 11'h668);
    evst(7'h07, fss_pkg::EV_STATION, 16'h0003, 11'h6e8);
    evst(7'h07, fss_pkg::EV_STATION, 16'h0007, 11'h668);
    evst(7'h07, fss_pkg::EV_CHECKSUM, 16'hbeee, 11'h768);
    evst(7'h07, fss_pkg::EV_CHECKSUM, 16'hbeef, 11'h668);
    evst(7'h07, fss_pkg::EV_ALARM, 16'h0, 11'h648);
    evst(7'h07, fss_pkg::EV_DIAG, 16'h0, 11'h608);
    st(7'h08, 11'h608);
  endtask : t_events

  // emulated station flags, with a slow engine
  task automatic t_emulation;
    stall <= 4'h3;
    wr(fss_pkg::OFS_MODE, 32'h1, fss_pkg::RESP_OKAY);
    evst(7'h0a, fss_pkg::EV_EMU_CLEAR, 16'h1, 11'h408);
    evst(7'h0a, fss_pkg::EV_EMU_ALARM, 16'h0, 11'h408);
    evst(7'h0a, fss_pkg::EV_EMU_ACK, 16'h0, 11'h008);
    wr(fss_pkg::OFS_MODE, 32'h0, fss_pkg::RESP_OKAY);
    st(7'h0a, 11'h608);
    wr(fss_pkg::OFS_MODE, 32'h1, fss_pkg::RESP_OKAY);
    evst(7'h0a, fss_pkg::EV_EMU_CLEAR, 16'h0, 11'h208);
    evst(7'h0a, fss_pkg::EV_EMU_ALARM, 16'h0, 11'h608);
  endtask : t_emulation

  // verdict and end of run
  task automatic end_sim;
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_sim

  // main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, go} = 5'h0;
    {s_axi_bready, s_axi_rready} = 2'h3;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    stall = 4'h0;
    {go_node, go_val} = 23'h0;
    go_code = fss_pkg::EV_ONLINE;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (130) @(posedge aclk);
    t_regs();
    t_exchange();
    t_events();
    t_emulation();
    end_sim();
  end

  // hang guard
  initial
  begin
    #300000;
    failures++;
    $display("MISMATCH at %0t: timeout", $time);
    end_sim();
  end
endmodule : testbench
